// *** rtl/fpio_defs.svh ***
// Offsets, field positions, reset values and fixed patterns of the FP I/O unit.
// Assumes inclusion by bare name from the unit's design files.
`ifndef FPIO_DEFS_SVH
`define FPIO_DEFS_SVH

// ==========================================
// Register byte offsets
`define FPIO_ADDR_CTRL   4'h0
`define FPIO_ADDR_STATUS 4'h4
`define FPIO_ADDR_RESULT 4'h8

// ==========================================
// Control register fields
`define FPIO_CTRL_FMT    0
`define FPIO_CTRL_BYP    1
`define FPIO_CTRL_SHARED 2
`define FPIO_CTRL_HALF   3
`define FPIO_CTRL_W      4
`define FPIO_CTRL_RST    4'h1

// ==========================================
// Float word layout and patterns
`define FPIO_SIGN_BIT    31
`define FPIO_SIGNAL_BIT  22
`define FPIO_QUIET_BIT   21
`define FPIO_EXP_MAX     8'hff
`define FPIO_EXP_ZERO    8'h00
`define FPIO_FRAC_ZERO   23'h000000
`define FPIO_QNAN_FIXED  32'h7fa00000
`define FPIO_HALF_W      16

`endif

// *** rtl/fpio_pkg.sv ***
// Types shared by the FP I/O unit: float word, operand class, op codes,
// I/O modes and flags. Constants live in fpio_defs.svh.
package fpio_pkg;

    typedef struct packed {
        logic        sign;
        logic [7:0]  exp;
        logic [22:0] frac;
    } fpio_word_t;

    typedef enum logic [2:0] {
        FPIO_CL_ZERO,
        FPIO_CL_DENORM,
        FPIO_CL_NORM,
        FPIO_CL_INF,
        FPIO_CL_NAN
    } fpio_class_t;

    typedef enum logic [2:0] {
        FPIO_OP_ADD     = 3'h0,
        FPIO_OP_SUB     = 3'h1,
        FPIO_OP_MUL     = 3'h2,
        FPIO_OP_TWO_S   = 3'h3,
        FPIO_OP_I2F     = 3'h4,
        FPIO_OP_F2I     = 3'h5,
        FPIO_OP_TO_ALT  = 3'h6,
        FPIO_OP_FROM_ALT = 3'h7
    } fpio_op_t;

    typedef enum logic [1:0] {
        FPIO_MODE_TWO_BUS,
        FPIO_MODE_SHARED,
        FPIO_MODE_HALF
    } fpio_mode_t;

    typedef struct packed {
        logic invalid;
        logic nan;
    } fpio_flags_t;

endpackage

// *** rtl/fpio_nan_unit.sv ***
// Exception stage of the FP ALU: operand classes, NaN and invalid handling.
// Assumes operands come from the data path registers on the same clock.
`timescale 1ns/100ps
`include "fpio_defs.svh"
module fpio_nan_unit (
    // Operands and operation
    input  wire logic [31:0]      i_r,
    input  wire logic [31:0]      i_s,
    input  wire fpio_pkg::fpio_op_t i_op,
    input  wire logic             i_ieee,
    // Result and flags
    output logic [31:0]           o_f,
    output fpio_pkg::fpio_flags_t o_flags,
    output fpio_pkg::fpio_class_t o_r_class,
    output fpio_pkg::fpio_class_t o_s_class
);
    fpio_pkg::fpio_word_t r_w;
    fpio_pkg::fpio_word_t s_w;
    fpio_pkg::fpio_word_t nan_src;
    logic r_used, s_used, r_nan, s_nan, r_snan, s_snan;
    logic r_inf, s_inf, r_zero, s_zero, inf_clash, no_nan_inv;
    logic any_nan, res_nan, inv_flag;
    logic [31:0] quieted;
    logic [31:0] core_f;

    function automatic fpio_pkg::fpio_class_t classify(input fpio_pkg::fpio_word_t w);
        fpio_pkg::fpio_class_t c;
        c = fpio_pkg::FPIO_CL_NORM;
        if (w.exp == `FPIO_EXP_ZERO) begin
            c = (w.frac == `FPIO_FRAC_ZERO) ? fpio_pkg::FPIO_CL_ZERO : fpio_pkg::FPIO_CL_DENORM;
        end else if (w.exp == `FPIO_EXP_MAX) begin
            c = (w.frac == `FPIO_FRAC_ZERO) ? fpio_pkg::FPIO_CL_INF : fpio_pkg::FPIO_CL_NAN;
        end
        return c;
    endfunction

    assign r_w       = i_r;
    assign s_w       = i_s;
    assign o_r_class = classify(r_w);
    assign o_s_class = classify(s_w);
    // 2-S ignores R; single-operand ops ignore S
    assign r_used    = (i_op != fpio_pkg::FPIO_OP_TWO_S);
    assign s_used    = (i_op <= fpio_pkg::FPIO_OP_TWO_S);
    assign r_nan     = r_used && (o_r_class == fpio_pkg::FPIO_CL_NAN);
    assign s_nan     = s_used && (o_s_class == fpio_pkg::FPIO_CL_NAN);
    assign r_snan    = r_nan && i_r[`FPIO_SIGNAL_BIT];
    assign s_snan    = s_nan && i_s[`FPIO_SIGNAL_BIT];
    assign r_inf     = o_r_class == fpio_pkg::FPIO_CL_INF;
    assign s_inf     = o_s_class == fpio_pkg::FPIO_CL_INF;
    // Denormals act as zero
    assign r_zero    = o_r_class inside {fpio_pkg::FPIO_CL_ZERO, fpio_pkg::FPIO_CL_DENORM};
    assign s_zero    = o_s_class inside {fpio_pkg::FPIO_CL_ZERO, fpio_pkg::FPIO_CL_DENORM};
    assign inf_clash = (i_op == fpio_pkg::FPIO_OP_ADD && r_inf && s_inf && (r_w.sign != s_w.sign))
                    || (i_op == fpio_pkg::FPIO_OP_SUB && r_inf && s_inf && (r_w.sign == s_w.sign))
                    || (i_op == fpio_pkg::FPIO_OP_MUL && ((r_inf && s_zero) || (r_zero && s_inf)));
    assign any_nan   = r_nan || s_nan;
    assign no_nan_inv = inf_clash && !any_nan;
    assign nan_src   = r_nan ? r_w : s_w;
    // Sign cleared, bit 22 low, bit 21 high
    assign quieted   = {1'b0, nan_src.exp, 1'b0, 1'b1, nan_src.frac[20:0]};
    // Arithmetic proper is outside this stage: the used operand is forwarded
    assign core_f    = r_used ? i_r : i_s;

    always_comb begin
        o_f = core_f;
        inv_flag = 1'b0;
        if (i_ieee) begin
            if (any_nan) begin
                o_f = quieted;
                inv_flag = r_snan || s_snan || (i_op == fpio_pkg::FPIO_OP_F2I);
            end else if (no_nan_inv) begin
                o_f = `FPIO_QNAN_FIXED;
                inv_flag = 1'b1;
            end
        end
    end

    assign res_nan   = (o_f[30:23] == `FPIO_EXP_MAX) && (o_f[22:0] != `FPIO_FRAC_ZERO);
    // One driver for the whole flag struct
    assign o_flags = {inv_flag, i_ieee && res_nan};
endmodule

// *** rtl/fpio_top.sv ***
// FP unit data path: operand muxes, R/S/F registers, three I/O modes,
// IEEE operand classes and NaN rules, with an Avalon-MM register slave.
// Assumes the host drives buses and strobes from logic on I_SYS_CLK.
//
// Design decisions made here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/100ps
`include "fpio_defs.svh"
module fpio_top (
    // Clock and reset
    input  wire logic        I_SYS_CLK,
    input  wire logic        I_RST,
    // Operand buses
    input  wire logic [31:0] I_R_BUS,
    input  wire logic [31:0] I_S_BUS,
    // Per-cycle controls
    input  wire logic [2:0]  I_ALU_OP,
    input  wire logic        I_R_REG_SOURCE_SELECT,
    input  wire logic        I_ALU_S_SOURCE_SELECT,
    input  wire logic        I_R_REG_LOAD_N,
    input  wire logic        I_S_REG_LOAD_N,
    input  wire logic        I_RESULT_REG_LOAD_N,
    // Result bus and flags
    output logic [31:0]      O_F_BUS,
    output logic             O_FLAG_INVALID,
    output logic             O_FLAG_NAN,
    // Avalon-MM slave
    input  wire logic [3:0]  I_AVS_ADDRESS,
    input  wire logic        I_AVS_READ,
    input  wire logic        I_AVS_WRITE,
    input  wire logic [31:0] I_AVS_WRITEDATA,
    input  wire logic [3:0]  I_AVS_BYTEENABLE,
    output logic [31:0]      O_AVS_READDATA,
    output logic             O_AVS_WAITREQUEST
);
    // ==========================================
    // Control register and mode decode
    logic [`FPIO_CTRL_W-1:0] ctrl;
    logic [`FPIO_CTRL_W-1:0] next_ctrl;
    fpio_pkg::fpio_mode_t    mode;
    wire float_format_select = ctrl[`FPIO_CTRL_FMT];
    wire input_reg_bypass    = ctrl[`FPIO_CTRL_BYP];
    wire shared_input_bus_select = ctrl[`FPIO_CTRL_SHARED];
    wire half_width_io_select    = ctrl[`FPIO_CTRL_HALF];

    // Illegal code 11 falls back to two-bus
    assign mode = (half_width_io_select && !shared_input_bus_select) ? fpio_pkg::FPIO_MODE_HALF :
                  (shared_input_bus_select && !half_width_io_select) ? fpio_pkg::FPIO_MODE_SHARED :
                  fpio_pkg::FPIO_MODE_TWO_BUS;

    wire is_half   = (mode == fpio_pkg::FPIO_MODE_HALF);
    wire is_shared = (mode == fpio_pkg::FPIO_MODE_SHARED);

    // ==========================================
    // Falling-edge holding registers
    logic [31:0] hold_s;
    logic [15:0] hold_r_lo;
    logic [15:0] hold_s_lo;

    always_ff @(negedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            hold_s    <= 32'h0;
            hold_r_lo <= 16'h0;
            hold_s_lo <= 16'h0;
        end else begin
            hold_s    <= I_S_BUS;
            hold_r_lo <= I_R_BUS[15:0];
            hold_s_lo <= I_S_BUS[15:0];
        end
    end

    // ==========================================
    // Operand assembly per mode
    logic [31:0] r_reg, s_reg, f_reg;
    logic [31:0] alu_f, alu_s, r_bus_word, s_bus_word;
    logic [31:0] r_in, r_op, s_op;

    // Half-width: both bus halves carry the same 16 bits
    assign r_bus_word = is_half ? {I_R_BUS[15:0], hold_r_lo} : I_R_BUS;
    assign s_bus_word = is_half ? {I_S_BUS[15:0], hold_s_lo} :
                        is_shared ? hold_s : I_S_BUS;
    assign r_in  = I_R_REG_SOURCE_SELECT ? alu_f : r_bus_word;
    // Transparency only valid in two-bus mode; host keeps it low otherwise
    assign r_op  = input_reg_bypass ? r_in : r_reg;
    assign s_op  = input_reg_bypass ? s_bus_word : s_reg;
    assign alu_s = I_ALU_S_SOURCE_SELECT ? f_reg : s_op;

    // ==========================================
    // ALU exception stage, identical in every mode
    fpio_pkg::fpio_flags_t alu_flags;
    fpio_pkg::fpio_class_t r_class, s_class;

    fpio_nan_unit u_nan (
        .i_r       (r_op),
        .i_s       (alu_s),
        .i_op      (fpio_pkg::fpio_op_t'(I_ALU_OP)),
        .i_ieee    (float_format_select),
        .o_f       (alu_f),
        .o_flags   (alu_flags),
        .o_r_class (r_class),
        .o_s_class (s_class)
    );

    // ==========================================
    // Rising-edge data registers and flags
    fpio_pkg::fpio_flags_t flags;

    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            r_reg <= 32'h0;
            s_reg <= 32'h0;
            f_reg <= 32'h0;
            flags <= '0;
        end else begin
            if (!I_R_REG_LOAD_N) r_reg <= r_in;
            if (!I_S_REG_LOAD_N) s_reg <= s_bus_word;
            if (!I_RESULT_REG_LOAD_N) f_reg <= alu_f;
            flags <= alu_flags;
        end
    end

    // ==========================================
    // Result bus
    // Half-width lanes follow the clock level itself, so this is the one
    // output that passes a gate after its flip-flop.
    logic [31:0] f_lo_dup, f_hi_dup;

    assign f_lo_dup = {f_reg[15:0], f_reg[15:0]};
    assign f_hi_dup = {f_reg[31:16], f_reg[31:16]};
    assign O_F_BUS  = !is_half ? f_reg : (I_SYS_CLK ? f_lo_dup : f_hi_dup);
    assign O_FLAG_INVALID = flags.invalid;
    assign O_FLAG_NAN     = flags.nan;

    // ==========================================
    // Avalon-MM slave, one wait state per access
    logic        waitreq;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    wire         req     = I_AVS_READ || I_AVS_WRITE;
    wire         accept  = req && !waitreq;
    wire         sel_ctrl = (I_AVS_ADDRESS == `FPIO_ADDR_CTRL);
    wire         sel_stat = (I_AVS_ADDRESS == `FPIO_ADDR_STATUS);
    wire         sel_res  = (I_AVS_ADDRESS == `FPIO_ADDR_RESULT);
    wire [31:0]  status_word = {22'h0, mode, s_class, r_class, flags.nan, flags.invalid};

    assign next_ctrl = (accept && I_AVS_WRITE && sel_ctrl && I_AVS_BYTEENABLE[0]) ?
                       I_AVS_WRITEDATA[`FPIO_CTRL_W-1:0] : ctrl;
    // Unmapped addresses read as zero and ignore writes
    assign next_rdata = sel_ctrl ? {28'h0, ctrl} :
                        sel_stat ? status_word :
                        sel_res  ? f_reg : 32'h0;

    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            waitreq <= 1'b1;
            rdata   <= 32'h0;
            ctrl    <= `FPIO_CTRL_RST;
        end else begin
            waitreq <= !(req && waitreq);
            if (req && waitreq) rdata <= next_rdata;
            ctrl    <= next_ctrl;
        end
    end

    assign O_AVS_WAITREQUEST = waitreq;
    assign O_AVS_READDATA    = rdata;

    // ==========================================
    // Assertions
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (I_RST);

    wire alu_is_nan = (alu_f[30:23] == `FPIO_EXP_MAX) && (alu_f[22:0] != 23'h0);

    a_r_hold_off: assert property (I_R_REG_LOAD_N |=> $stable(r_reg))
        else $error("R register changed while load disabled");

    a_r_from_alu: assert property (!I_R_REG_LOAD_N && I_R_REG_SOURCE_SELECT |=> r_reg == $past(alu_f))
        else $error("R register did not take the ALU result");

    a_s_port_mux: assert property (I_ALU_S_SOURCE_SELECT && $stable(f_reg) |-> alu_s == $past(f_reg))
        else $error("ALU S port not fed from F register");

    a_two_bus_s: assert property (mode == fpio_pkg::FPIO_MODE_TWO_BUS && !I_S_REG_LOAD_N
        |=> s_reg == $past(I_S_BUS))
        else $error("Two-bus mode S register missed the S bus");

    a_shared_s: assert property (is_shared && !I_S_REG_LOAD_N |=> s_reg == $past(hold_s))
        else $error("Shared-bus S register missed the held operand");

    a_half_join: assert property (is_half && !I_R_REG_LOAD_N && !I_R_REG_SOURCE_SELECT
        |=> r_reg == {$past(I_R_BUS[15:0]), $past(hold_r_lo)})
        else $error("Half-width R halves joined wrongly");

    a_illegal_two: assert property (half_width_io_select && shared_input_bus_select
        |-> mode == fpio_pkg::FPIO_MODE_TWO_BUS)
        else $error("Illegal mode code not handled as two-bus");

    a_nan_sign_low: assert property (float_format_select && alu_is_nan
        |-> !alu_f[`FPIO_SIGN_BIT] && !alu_f[`FPIO_SIGNAL_BIT] && alu_f[`FPIO_QUIET_BIT])
        else $error("Output NaN not quiet with clear sign");

    a_nan_flag: assert property (##1 flags.nan == $past(float_format_select && alu_is_nan))
        else $error("NaN flag does not follow the result");

    a_snan_invalid: assert property (float_format_select && r_class == fpio_pkg::FPIO_CL_NAN
        && r_op[`FPIO_SIGNAL_BIT] && I_ALU_OP != 3'h3 |=> flags.invalid)
        else $error("Signalling NaN did not raise invalid");

    a_fixed_qnan: assert property (float_format_select && alu_flags.invalid && !alu_is_nan == 1'b0
        && r_class != fpio_pkg::FPIO_CL_NAN && s_class != fpio_pkg::FPIO_CL_NAN
        |-> alu_f == `FPIO_QNAN_FIXED)
        else $error("Invalid without NaN gave wrong pattern");

    a_bus_answer: assert property (req && waitreq |=> !waitreq ##1 waitreq)
        else $error("Bus answer not one cycle after request");

    c_shared_load: cover property (is_shared && !I_S_REG_LOAD_N ##1 !I_R_REG_LOAD_N);
    c_half_load:   cover property (is_half && !I_R_REG_LOAD_N && !I_S_REG_LOAD_N);
    c_two_nans:    cover property (float_format_select && r_class == fpio_pkg::FPIO_CL_NAN
                                   && s_class == fpio_pkg::FPIO_CL_NAN);
    c_fixed_qnan:  cover property (alu_f == `FPIO_QNAN_FIXED && alu_flags.invalid);
    c_bypass:      cover property (input_reg_bypass && I_R_REG_LOAD_N && I_S_REG_LOAD_N);
endmodule

// *** verif/fpio_host_model.sv ***
// Host model: presents R and S operands on the buses for each I/O mode.
// Assumes the bench sets operands and mode, and holds them for some cycles.
`timescale 1ns/100ps
module fpio_host_model (
    // Clock and mode
    input  wire logic                 i_clk,
    input  wire fpio_pkg::fpio_mode_t i_mode,
    // Operands to present
    input  wire logic [31:0]          i_r_op,
    input  wire logic [31:0]          i_s_op,
    // Bus lines into the device
    output logic [31:0]               o_r_bus,
    output logic [31:0]               o_s_bus
);
    // ==========================================
    // Phase drive
    // Buses change just after each edge, so no capture races an update
    always @(i_clk) begin
        case (i_mode)
            fpio_pkg::FPIO_MODE_SHARED: begin
                o_r_bus <= i_clk ? i_s_op : i_r_op;
                o_s_bus <= i_clk ? i_s_op : i_r_op;
            end
            fpio_pkg::FPIO_MODE_HALF: begin
                o_r_bus <= i_clk ? {2{i_r_op[15:0]}} : {2{i_r_op[31:16]}};
                o_s_bus <= i_clk ? {2{i_s_op[15:0]}} : {2{i_s_op[31:16]}};
            end
            default: begin
                o_r_bus <= i_r_op;
                o_s_bus <= i_s_op;
            end
        endcase
    end
endmodule

// *** verif/fpio_top_test.sv ***
// Self-checking bench for the FP unit: muxes, load enables, I/O modes, NaN rules.
// Assumes fpio_host_model drives the operand buses; registers over Avalon-MM.
`timescale 1ns/100ps
`include "fpio_defs.svh"
module fpio_top_test;
    // ==========================================
    // Signals
    logic                 clk      = 1'b0;
    logic                 rst      = 1'b1;
    fpio_pkg::fpio_mode_t mode     = fpio_pkg::FPIO_MODE_TWO_BUS;
    logic [31:0]          r_op     = 32'h0;
    logic [31:0]          s_op     = 32'h0;
    logic [2:0]           alu_op   = 3'h0;
    logic                 r_src    = 1'b0;
    logic                 s_src    = 1'b0;
    logic                 r_ld_n   = 1'b0;
    logic                 s_ld_n   = 1'b0;
    logic                 f_ld_n   = 1'b0;
    logic [3:0]           av_addr  = 4'h0;
    logic                 av_rd    = 1'b0;
    logic                 av_wr    = 1'b0;
    logic [31:0]          av_wdata = 32'h0;
    logic [31:0]          rd_data;
    logic [31:0]          r_bus;
    logic [31:0]          s_bus;
    logic [31:0]          f_bus;
    logic [31:0]          av_rdata;
    logic                 f_inv;
    logic                 f_nan;
    logic                 av_wait;
    int                   num_errors  = 0;
    int                   comparisons = 0;

    always #12.5 clk = ~clk;

    fpio_host_model host (.i_clk(clk), .i_mode(mode), .i_r_op(r_op), .i_s_op(s_op), .o_r_bus(r_bus), .o_s_bus(s_bus));
    fpio_top uut (
        .I_SYS_CLK(clk), .I_RST(rst), .I_R_BUS(r_bus), .I_S_BUS(s_bus), .I_ALU_OP(alu_op),
        .I_R_REG_SOURCE_SELECT(r_src), .I_ALU_S_SOURCE_SELECT(s_src), .I_R_REG_LOAD_N(r_ld_n),
        .I_S_REG_LOAD_N(s_ld_n), .I_RESULT_REG_LOAD_N(f_ld_n), .O_F_BUS(f_bus), .O_FLAG_INVALID(f_inv),
        .O_FLAG_NAN(f_nan), .I_AVS_ADDRESS(av_addr), .I_AVS_READ(av_rd), .I_AVS_WRITE(av_wr),
        .I_AVS_WRITEDATA(av_wdata), .I_AVS_BYTEENABLE(4'hf), .O_AVS_READDATA(av_rdata),
        .O_AVS_WAITREQUEST(av_wait));

    // ==========================================
    // Checks and report
    task automatic check_word(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic check_bit(input string n, input logic e, input logic g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s expected %b seen %b", n, e, g);
        end
    endtask

    task automatic end_of_test();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ==========================================
    // Bus and operation helpers
    task automatic bus_access(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        av_addr <= a;
        av_wdata <= d;
        av_wr <= wr;
        av_rd <= !wr;
        // Waitrequest is sampled as it stood before the edge
        do begin
            @(posedge clk);
            n++;
        end while (av_wait !== 1'b0 && n < 20);
        if (n >= 20) begin
            num_errors++;
            end_of_test();
        end
        rd_data = av_rdata;
        av_wr <= 1'b0;
        av_rd <= 1'b0;
    endtask

    task automatic set_mode(input fpio_pkg::fpio_mode_t m, input logic fmt);
        bus_access(1'b1, `FPIO_ADDR_CTRL, {28'h0, m == fpio_pkg::FPIO_MODE_HALF,
                                           m == fpio_pkg::FPIO_MODE_SHARED, 1'b0, fmt});
        // Host follows at the edge on which the new mode lands
        mode <= m;
        bus_access(1'b0, `FPIO_ADDR_STATUS, 32'h0);
        check_word("mode", {30'h0, m}, {30'h0, rd_data[9:8]});
    endtask

    task automatic settle();
        repeat (4) @(posedge clk);
        #1;
    endtask

    task automatic check_f(input logic [31:0] e);
        if (mode == fpio_pkg::FPIO_MODE_HALF) begin
            @(posedge clk);
            #2;
            check_word("f bus low", {2{e[15:0]}}, f_bus);
            @(negedge clk);
            #2;
            check_word("f bus high", {2{e[31:16]}}, f_bus);
        end else begin
            check_word("f bus", e, f_bus);
        end
    endtask

    task automatic nan_case(input logic [2:0] op, input logic [31:0] r, input logic [31:0] s,
                            input logic [31:0] f, input logic inv, input logic nan);
        @(posedge clk);
        alu_op <= op;
        r_op <= r;
        s_op <= s;
        settle();
        check_bit("invalid", inv, f_inv);
        check_bit("nan", nan, f_nan);
        check_f(f);
    endtask

    // ==========================================
    // Scenarios
    task automatic test_reset();
        #1;
        check_word("f after reset", 32'h0, f_bus);
        bus_access(1'b0, `FPIO_ADDR_CTRL, 32'h0);
        check_word("ctrl reset", {28'h0, `FPIO_CTRL_RST}, rd_data);
    endtask

    task automatic test_nan_rules();
        nan_case(3'h0, 32'h3f800000, 32'h7fc12345, 32'h7fa12345, 1'b1, 1'b1);
        nan_case(3'h2, 32'hfff11111, 32'h7fc22222, 32'h7fb11111, 1'b1, 1'b1);
        nan_case(3'h1, 32'hff800001, 32'h7f800000, 32'h7fa00001, 1'b0, 1'b1);
        nan_case(3'h5, 32'hff800001, 32'h40600000, 32'h7fa00001, 1'b1, 1'b1);
        nan_case(3'h0, 32'h7f800000, 32'hff800000, 32'h7fa00000, 1'b1, 1'b1);
        nan_case(3'h2, 32'h7f800000, 32'h00000000, 32'h7fa00000, 1'b1, 1'b1);
        nan_case(3'h0, 32'h40600000, 32'h3f800000, 32'h40600000, 1'b0, 1'b0);
        nan_case(3'h4, 32'h40600000, 32'h7fc12345, 32'h40600000, 1'b0, 1'b0);
    endtask

    task automatic test_regs();
        bus_access(1'b0, 4'hc, 32'h0);
        check_word("unmapped read", 32'h0, rd_data);
        bus_access(1'b1, 4'hc, 32'hffffffff);
        bus_access(1'b1, `FPIO_ADDR_RESULT, 32'h12345678);
        bus_access(1'b0, `FPIO_ADDR_RESULT, 32'h0);
        check_word("result reg", 32'h40600000, rd_data);
        bus_access(1'b0, `FPIO_ADDR_CTRL, 32'h0);
        check_word("ctrl kept", {28'h0, `FPIO_CTRL_RST}, rd_data);
    endtask

    task automatic test_classes();
        logic [31:0] v [7] = '{32'h0, 32'h1, 32'h00800000, 32'h7f7fffff, 32'h7f800000, 32'h7fc00000, 32'hff800001};
        fpio_pkg::fpio_class_t c [7] = '{fpio_pkg::FPIO_CL_ZERO, fpio_pkg::FPIO_CL_DENORM, fpio_pkg::FPIO_CL_NORM,
            fpio_pkg::FPIO_CL_NORM, fpio_pkg::FPIO_CL_INF, fpio_pkg::FPIO_CL_NAN, fpio_pkg::FPIO_CL_NAN};
        for (int i = 0; i < 7; i++) begin
            r_op <= v[i];
            s_op <= v[i];
            settle();
            bus_access(1'b0, `FPIO_ADDR_STATUS, 32'h0);
            check_word("r class", {29'h0, c[i]}, {29'h0, rd_data[4:2]});
            check_word("s class", {29'h0, c[i]}, {29'h0, rd_data[7:5]});
        end
    endtask

    task automatic test_muxes();
        nan_case(3'h0, 32'hfff11111, 32'h40600000, 32'h7fb11111, 1'b1, 1'b1);
        // Fed back result is quiet, so invalid must drop with the bus unchanged
        @(posedge clk);
        r_src <= 1'b1;
        settle();
        check_bit("invalid", 1'b0, f_inv);
        check_f(32'h7fb11111);
        @(posedge clk);
        r_src <= 1'b0;
        nan_case(3'h3, 32'h0, 32'h40600000, 32'h40600000, 1'b0, 1'b0);
        @(posedge clk);
        s_op <= 32'h3f800000;
        s_src <= 1'b1;
        settle();
        check_f(32'h40600000);
        @(posedge clk);
        s_src <= 1'b0;
        settle();
        check_f(32'h3f800000);
    endtask

    task automatic test_load_enables();
        nan_case(3'h0, 32'h40e00000, 32'h3f800000, 32'h40e00000, 1'b0, 1'b0);
        @(posedge clk);
        r_ld_n <= 1'b1;
        s_ld_n <= 1'b1;
        nan_case(3'h0, 32'h3f800000, 32'h7fc00001, 32'h40e00000, 1'b0, 1'b0);
        @(posedge clk);
        r_ld_n <= 1'b0;
        s_ld_n <= 1'b0;
        f_ld_n <= 1'b1;
        nan_case(3'h0, 32'h7f800000, 32'hff800000, 32'h40e00000, 1'b1, 1'b1);
        @(posedge clk);
        f_ld_n <= 1'b0;
        settle();
        check_f(32'h7fa00000);
    endtask

    task automatic test_modes();
        set_mode(fpio_pkg::FPIO_MODE_SHARED, 1'b1);
        nan_case(3'h0, 32'h3f800000, 32'h7fc12345, 32'h7fa12345, 1'b1, 1'b1);
        nan_case(3'h3, 32'h40e00000, 32'h40600000, 32'h40600000, 1'b0, 1'b0);
        nan_case(3'h0, 32'h40e00000, 32'h40600000, 32'h40e00000, 1'b0, 1'b0);
        set_mode(fpio_pkg::FPIO_MODE_HALF, 1'b1);
        nan_case(3'h2, 32'hfff11111, 32'h7fc22222, 32'h7fb11111, 1'b1, 1'b1);
        nan_case(3'h0, 32'h40e01234, 32'h3f805678, 32'h40e01234, 1'b0, 1'b0);
        nan_case(3'h3, 32'h40e01234, 32'h3f805678, 32'h3f805678, 1'b0, 1'b0);
        set_mode(fpio_pkg::FPIO_MODE_TWO_BUS, 1'b1);
    endtask

    task automatic test_format();
        set_mode(fpio_pkg::FPIO_MODE_TWO_BUS, 1'b0);
        nan_case(3'h0, 32'hfff11111, 32'h40600000, 32'hfff11111, 1'b0, 1'b0);
        set_mode(fpio_pkg::FPIO_MODE_TWO_BUS, 1'b1);
    endtask

    // Registers held, so only a transparent path can deliver the new operands
    task automatic test_bypass();
        bus_access(1'b1, `FPIO_ADDR_CTRL, 32'h3);
        r_ld_n <= 1'b1;
        s_ld_n <= 1'b1;
        nan_case(3'h0, 32'h40e00000, 32'h3f800000, 32'h40e00000, 1'b0, 1'b0);
        @(posedge clk);
        r_ld_n <= 1'b0;
        s_ld_n <= 1'b0;
        bus_access(1'b1, `FPIO_ADDR_CTRL, {28'h0, `FPIO_CTRL_RST});
    endtask

    // ==========================================
    // Main sequence and watchdog
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        test_reset();
        test_nan_rules();
        test_regs();
        test_classes();
        test_muxes();
        test_load_enables();
        test_modes();
        test_format();
        test_bypass();
        end_of_test();
    end

    initial begin
        #1000000;
        num_errors++;
        end_of_test();
    end
endmodule
